// *** shared/adcs_pkg.sv ***
// Constants, types and register map of the converter control port.
// Assumes one system clock; serial pins arrive synchronous to it.
package adcs_pkg;

	// ----------------------------------------
	// Access framing
	// ----------------------------------------
	localparam int REG_W = 8;
	localparam int ADDR_W = 4;
	localparam int FRAME_BITS = 16;
	localparam int CMD_BITS = 8;
	localparam logic [4:0] CNT_CMD_DONE = 5'h08;
	localparam logic [4:0] CNT_LAST_OUT = 5'h0f;
	localparam logic [4:0] CNT_FULL = 5'h10;
	localparam int RW_POS = 15;
	localparam int ADDR_LSB = 8;
	localparam int SAMPLE_W = 12;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] ADDR_DEV_CTRL = 4'h0;
	localparam logic [3:0] ADDR_PAT_HI = 4'h1;
	localparam logic [3:0] ADDR_PAT_LO = 4'h2;
	localparam logic [3:0] PTR_RESET = 4'h0;
	localparam logic [7:0] DEV_CTRL_RESET = 8'h08;
	localparam logic [7:0] PAT_HI_RESET = 8'h00;
	localparam logic [7:0] PAT_LO_RESET = 8'h00;
	localparam logic [7:0] PAT_HI_MASK = 8'h3f;
	localparam int MODE_LSB = 6;
	localparam int LANE_POS = 5;
	localparam int DCS_POS = 4;
	localparam int CODING_POS = 3;
	localparam int ALIGN_POS = 2;
	localparam int PDA_POS = 1;
	localparam int PDB_POS = 0;
	localparam logic [11:0] FIXED_PATTERN = 12'ha63;

	typedef enum logic [1:0] {MODE_NORMAL, MODE_FIXED, MODE_USER, MODE_RSVD} adcs_mode_e;
	typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA, PH_DONE} adcs_phase_e;

	typedef struct packed {
		adcs_mode_e mode;
		logic singleLane;
		logic dutyStab;
		logic twosComp;
		logic wordAlign;
		logic pdA;
		logic pdB;
		logic [11:0] userPattern;
	} adcs_ctrl_s;

	typedef struct packed {
		logic [11:0] upper;
		logic [5:0] lower;
		logic lowerEn;
		logic overrange;
		logic active;
	} adcs_lane_s;

endpackage : adcs_pkg

// *** rtl/adcs_lane_fmt.sv ***
// Per-channel output word former: pattern select, coding, lane split.
// Assumes frameStrobe pulses once per output frame in mclk domain.
`timescale 1ns/1ps
module adcs_lane_fmt (
	input wire logic mclk,
	input wire logic nrst,
	input wire adcs_pkg::adcs_ctrl_s ctrl,
	input wire logic powerDown,
	input wire logic [adcs_pkg::SAMPLE_W-1:0] sample,
	input wire logic overrangeIn,
	input wire logic frameStrobe,
	output adcs_pkg::adcs_lane_s laneOut
);
	import adcs_pkg::*;

	logic [SAMPLE_W-1:0] word;
	logic [5:0] prevHigh_q;
	adcs_lane_s lane_q;

	// ----------------------------------------
	// Word source
	// ----------------------------------------
	always_comb begin
		case (ctrl.mode)
			MODE_NORMAL: word = ctrl.twosComp ? {~sample[11], sample[10:0]} : sample;
			MODE_FIXED: word = FIXED_PATTERN;
			MODE_USER: word = ctrl.userPattern;
			default: word = '0;
		endcase
	end

	// ----------------------------------------
	// Frame update
	// ----------------------------------------
	// Dual lane carries six bits per lane, so each lane runs at half rate
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			lane_q <= '0;
			prevHigh_q <= '0;
		end else if (frameStrobe) begin
			lane_q.overrange <= overrangeIn;
			lane_q.active <= !powerDown;
			lane_q.lowerEn <= !ctrl.singleLane;
			if (!powerDown) begin
				prevHigh_q <= word[11:6];
				if (ctrl.singleLane) begin
					lane_q.upper <= word;
					lane_q.lower <= '0;
				end else begin
					lane_q.upper <= {6'h00, ctrl.wordAlign ? prevHigh_q : word[11:6]};
					lane_q.lower <= word[5:0];
				end
			end
		end
	end

	assign laneOut = lane_q;

endmodule : adcs_lane_fmt

// *** rtl/adcs_serial_ctrl.sv ***
// Serial control port with three control registers and two lane formers.
// Assumes serial pins are synchronous to mclk and far slower than it.
//
// Notes on behaviour
// - An access is sixteen serial clocks with select held low; clocks past sixteen are ignored.
// - A write finishes in one access while the data phase returns register contents.
// - Input sampled on serial clock rise; output changes on its fall.
// - Each select assertion restarts the bit count and expects a command.
// - Select released before sixteen clocks: no address latch, no write.
// - Select rise latches the address and commits a write.
// - Command flag one means read, zero means write.
// - Write data stored at select release; read data field ignored.
// - Serial output floats unless select is asserted.
// - Register at the previous full access's address shifts out over falling edges eight to fifteen.
// - Readback pointer resets to register zero.
// - Mode field picks normal, fixed pattern, user pattern or reserved.
// - User pattern is register one bits 3:0 over register two.
// - Lane bit zero gives dual lane; one gives upper lane, lower floats.
// - Dual lane halves lane rate; both modes use double data rate.
// - Control bit four turns the duty-cycle stabiliser on.
// - Control bit three one gives two's complement, zero offset binary.
// - Align bit zero in single lane; in dual, one delays upper lane.
// - Power-down bits suspend channel A and channel B.
// - Each channel overrange flag refreshes once per frame.
`timescale 1ns/1ps
module adcs_serial_ctrl (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic serialClk,
	input wire logic serialSelectN,
	input wire logic serialInLine,
	output logic serialOutLine,
	output logic serialOutEn,
	input wire logic [1:0][adcs_pkg::SAMPLE_W-1:0] samples,
	input wire logic [1:0] overrangeIn,
	input wire logic frameStrobe,
	output adcs_pkg::adcs_ctrl_s ctrlOut,
	output adcs_pkg::adcs_lane_s [1:0] lanes
);
	import adcs_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic sclkPrev_q;
	logic selPrevN_q;
	logic sclkRise;
	logic sclkFall;
	logic selAssert;
	logic selRelease;
	logic [4:0] bitCnt_q;
	adcs_phase_e phase_q;
	logic [FRAME_BITS-1:0] shiftIn_q;
	logic [REG_W-1:0] outShift_q;
	logic sdo_q;
	logic oe_q;
	logic [ADDR_W-1:0] ptr_q;
	logic [REG_W-1:0] devCtrl_q;
	logic [REG_W-1:0] patHi_q;
	logic [REG_W-1:0] patLo_q;
	logic fullAccess;
	logic cmdRead;
	logic [ADDR_W-1:0] cmdAddr;
	logic [REG_W-1:0] cmdData;
	adcs_ctrl_s ctrl;
	adcs_ctrl_s ctrl_q;

	function automatic logic [REG_W-1:0] regRead(
		input logic [ADDR_W-1:0] a,
		input logic [REG_W-1:0] dc,
		input logic [REG_W-1:0] ph,
		input logic [REG_W-1:0] pl
	);
		case (a)
			ADDR_DEV_CTRL: regRead = dc;
			ADDR_PAT_HI: regRead = ph & PAT_HI_MASK;
			ADDR_PAT_LO: regRead = pl;
			default: regRead = '0;
		endcase
	endfunction : regRead

	// ----------------------------------------
	// Pin edge detection
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sclkPrev_q <= 1'b0;
			selPrevN_q <= 1'b1;
		end else begin
			sclkPrev_q <= serialClk;
			selPrevN_q <= serialSelectN;
		end
	end

	assign sclkRise = serialClk && !sclkPrev_q;
	assign sclkFall = !serialClk && sclkPrev_q;
	assign selAssert = !serialSelectN && selPrevN_q;
	assign selRelease = serialSelectN && !selPrevN_q;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	assign fullAccess = (bitCnt_q == CNT_FULL);
	assign cmdRead = shiftIn_q[RW_POS];
	assign cmdAddr = shiftIn_q[ADDR_LSB +: ADDR_W];
	assign cmdData = shiftIn_q[REG_W-1:0];

	// ----------------------------------------
	// Bit counter and access phase
	// ----------------------------------------
	// Clocks beyond sixteen are not counted, so the access stays full
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			bitCnt_q <= '0;
			phase_q <= PH_IDLE;
		end else if (selAssert) begin
			bitCnt_q <= '0;
			phase_q <= PH_CMD;
		end else if (serialSelectN) begin
			phase_q <= PH_IDLE;
		end else if (sclkRise && bitCnt_q != CNT_FULL) begin
			bitCnt_q <= bitCnt_q + 5'h01;
			case (phase_q)
				PH_CMD: if (bitCnt_q + 5'h01 == CNT_CMD_DONE) phase_q <= PH_DATA;
				PH_DATA: if (bitCnt_q + 5'h01 == CNT_FULL) phase_q <= PH_DONE;
				default: phase_q <= phase_q;
			endcase
		end
	end

	// ----------------------------------------
	// Input shift register
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			shiftIn_q <= '0;
		end else if (selAssert) begin
			shiftIn_q <= '0;
		end else if (!serialSelectN && sclkRise && bitCnt_q != CNT_FULL) begin
			shiftIn_q <= {shiftIn_q[FRAME_BITS-2:0], serialInLine};
		end
	end

	// ----------------------------------------
	// Output shifter
	// ----------------------------------------
	// Data comes from the pointer of the last full access
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			outShift_q <= '0;
			sdo_q <= 1'b0;
		end else if (selAssert) begin
			outShift_q <= regRead(ptr_q, devCtrl_q, patHi_q, patLo_q);
			sdo_q <= 1'b0;
		end else if (serialSelectN) begin
			sdo_q <= 1'b0;
		end else if (sclkFall && bitCnt_q >= CNT_CMD_DONE && bitCnt_q <= CNT_LAST_OUT) begin
			sdo_q <= outShift_q[REG_W-1];
			outShift_q <= {outShift_q[REG_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= !serialSelectN;
		end
	end

	assign serialOutLine = sdo_q;
	assign serialOutEn = oe_q;

	// ----------------------------------------
	// Address pointer
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ptr_q <= PTR_RESET;
		end else if (selRelease && fullAccess) begin
			ptr_q <= cmdAddr;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Reserved pattern bits are never stored, so they read back zero
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			devCtrl_q <= DEV_CTRL_RESET;
			patHi_q <= PAT_HI_RESET;
			patLo_q <= PAT_LO_RESET;
		end else if (selRelease && fullAccess && !cmdRead) begin
			case (cmdAddr)
				ADDR_DEV_CTRL: devCtrl_q <= cmdData;
				ADDR_PAT_HI: patHi_q <= cmdData & PAT_HI_MASK;
				ADDR_PAT_LO: patLo_q <= cmdData;
				default: devCtrl_q <= devCtrl_q;
			endcase
		end
	end

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	always_comb begin
		ctrl.mode = adcs_mode_e'(devCtrl_q[MODE_LSB +: 2]);
		ctrl.singleLane = devCtrl_q[LANE_POS];
		ctrl.dutyStab = devCtrl_q[DCS_POS];
		ctrl.twosComp = devCtrl_q[CODING_POS];
		// Align ignored in single lane, guarding against a host slip
		ctrl.wordAlign = devCtrl_q[ALIGN_POS] && !devCtrl_q[LANE_POS];
		ctrl.pdA = devCtrl_q[PDA_POS];
		ctrl.pdB = devCtrl_q[PDB_POS];
		// Twelve-bit word: bits 5:4 of register one fall outside it
		ctrl.userPattern = {patHi_q[3:0], patLo_q};
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ctrl_q <= '0;
		end else begin
			ctrl_q <= ctrl;
		end
	end

	assign ctrlOut = ctrl_q;

	// ----------------------------------------
	// Channel formers
	// ----------------------------------------
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		adcs_lane_fmt u_fmt (
			.mclk(mclk),
			.nrst(nrst),
			.ctrl(ctrl_q),
			.powerDown(ch == 0 ? ctrl_q.pdA : ctrl_q.pdB),
			.sample(samples[ch]),
			.overrangeIn(overrangeIn[ch]),
			.frameStrobe(frameStrobe),
			.laneOut(lanes[ch])
		);
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	sequence s_full_release;
		selRelease && fullAccess;
	endsequence

	sequence s_short_release;
		selRelease && !fullAccess;
	endsequence

	sequence s_write_ctrl;
		s_full_release ##0 (!cmdRead && cmdAddr == ADDR_DEV_CTRL);
	endsequence

	a_float_idle: assert property (
		serialSelectN |=> !serialOutEn
	) else $error("serial output driven while deselected");

	a_drive_sel: assert property (
		!serialSelectN |=> serialOutEn
	) else $error("serial output not driven while selected");

	a_count_restart: assert property (
		selAssert |=> bitCnt_q == 5'h00 && phase_q == PH_CMD
	) else $error("access did not restart on select");

	a_count_limit: assert property (
		bitCnt_q <= CNT_FULL
	) else $error("bit count beyond sixteen");

	a_rise_count: assert property (
		(!serialSelectN && !selAssert && sclkRise && bitCnt_q < CNT_FULL)
		|=> bitCnt_q == $past(bitCnt_q) + 5'h01
	) else $error("rising edge not counted");

	a_short_nowrite: assert property (
		s_short_release |=> $stable(devCtrl_q) && $stable(patLo_q) && $stable(ptr_q)
	) else $error("short access changed state");

	a_ctrl_write: assert property (
		s_write_ctrl |=> devCtrl_q == $past(cmdData) ##1 ctrl_q.twosComp == devCtrl_q[CODING_POS]
	) else $error("control write not committed");

	a_read_nowrite: assert property (
		(s_full_release ##0 cmdRead) |=> $stable(devCtrl_q) && $stable(patHi_q) && $stable(patLo_q)
	) else $error("read access wrote a register");

	a_ptr_latch: assert property (
		s_full_release |=> ptr_q == $past(cmdAddr)
	) else $error("address not latched at release");

	a_out_fall: assert property (
		$changed(sdo_q) && !serialSelectN |-> $past(sclkFall) && $past(bitCnt_q) >= CNT_CMD_DONE
	) else $error("output changed off a falling edge");

	a_first_bit: assert property (
		(selAssert ##1 (!serialSelectN && !sclkFall && bitCnt_q != CNT_CMD_DONE)[*2])
		|-> sdo_q == 1'b0
	) else $error("output not quiet in command byte");

	a_pat_reserved: assert property (
		patHi_q[7:6] == 2'b00 ##1 ctrl_q.userPattern == {$past(patHi_q[3:0]), $past(patLo_q)}
	) else $error("user pattern high bits wrong");

	a_align_single: assert property (
		devCtrl_q[LANE_POS] |-> !ctrl.wordAlign
	) else $error("word align active in single lane");

endmodule : adcs_serial_ctrl

// *** bench/adcs_host_model.sv ***
// Behavioural serial master that drives the control port pins.
// Assumes the bench hands in the resolved output wire and calls access().
`timescale 1ns/1ps
module adcs_host_model (
	input wire logic mclk,
	input wire logic serialOutWire,
	output logic serialClk,
	output logic serialSelectN,
	output logic serialInLine
);
	import adcs_pkg::*;

	initial begin
		serialClk = 1'b0;
		serialSelectN = 1'b1;
		serialInLine = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge mclk);
	endtask : hold

	// Each phase lasts three mclk, above the one the port needs to see it
	task automatic access(input logic [15:0] word, input int nClk, output logic [7:0] rd);
		rd = 8'h00;
		serialSelectN = 1'b0;
		hold(3);
		for (int i = 0; i < nClk; i++) begin
			if (i >= CMD_BITS) rd[FRAME_BITS-1-i] = serialOutWire;
			serialInLine = word[FRAME_BITS-1-i];
			hold(3);
			serialClk = 1'b1;
			hold(3);
			serialClk = 1'b0;
			hold(3);
		end
		serialSelectN = 1'b1;
		// Released data line must not keep its last level
		serialInLine = ~serialInLine;
		hold(4);
	endtask : access
endmodule : adcs_host_model

// *** bench/testbench.sv ***
// Self-checking bench for the control port, its registers and lane formers.
// Assumes the host model drives serial pins off the falling mclk edge.
`timescale 1ns/1ps
module testbench;
	import adcs_pkg::*;
	logic mclk;
	logic nrst;
	logic frameStrobe;
	logic [1:0][SAMPLE_W-1:0] samples;
	logic [1:0] overrangeIn;
	logic serialClk;
	logic serialSelectN;
	logic serialInLine;
	logic serialOutLine;
	logic serialOutEn;
	wire serialOutWire;
	adcs_ctrl_s ctrlOut;
	adcs_lane_s [1:0] lanes;
	logic [7:0] regsQ [0:2];
	logic [3:0] ptrQ;
	logic [5:0] prevHi [0:1];
	int fails;
	int nTests;

	assign serialOutWire = serialOutEn ? serialOutLine : 1'bz;

	adcs_serial_ctrl dut (.mclk(mclk), .nrst(nrst), .serialClk(serialClk), .serialSelectN(serialSelectN),
		.serialInLine(serialInLine), .serialOutLine(serialOutLine), .serialOutEn(serialOutEn),
		.samples(samples), .overrangeIn(overrangeIn), .frameStrobe(frameStrobe), .ctrlOut(ctrlOut),
		.lanes(lanes));

	adcs_host_model host (.mclk(mclk), .serialOutWire(serialOutWire), .serialClk(serialClk),
		.serialSelectN(serialSelectN), .serialInLine(serialInLine));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", nTests, fails);
		if (fails == 0 && nTests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : giveVerdict

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		nTests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// -------------------------------
	// Register mirror and expectations
	// -------------------------------
	function automatic logic [7:0] regAt(input logic [3:0] a);
		return (a < 4'h3) ? regsQ[a[1:0]] : 8'h00;
	endfunction : regAt

	function automatic logic [11:0] expWord(input int ch);
		case (regsQ[0][7:6])
			2'b00: return samples[ch] ^ {regsQ[0][CODING_POS], 11'h0};
			2'b01: return FIXED_PATTERN;
			2'b10: return {regsQ[1][3:0], regsQ[2]};
			default: return 12'h000;
		endcase
	endfunction : expWord

	// Align bit is forced off while single lane is chosen
	function automatic logic [19:0] expCtrl();
		logic [7:0] dc;
		dc = regsQ[0];
		if (dc[LANE_POS]) dc[ALIGN_POS] = 1'b0;
		return {dc, regsQ[1][3:0], regsQ[2]};
	endfunction : expCtrl

	// Readback comes from the pointer left by the previous full access
	task automatic acc(input logic rd, input logic [3:0] a, input logic [7:0] d, input int nClk);
		logic [7:0] got;
		logic [7:0] exp;
		exp = regAt(ptrQ);
		host.access({rd, 3'h0, a, d}, nClk, got);
		if (nClk == FRAME_BITS) begin
			chk("readback", {24'h0, exp}, {24'h0, got});
			if (!rd && a < 4'h3) begin
				regsQ[a[1:0]] = (a == ADDR_PAT_HI) ? (d & PAT_HI_MASK) : d;
			end
			ptrQ = a;
		end
		chk("serialOutEn", 32'h0, {31'h0, serialOutEn});
		chk("ctrlOut", {12'h0, expCtrl()}, {12'h0, ctrlOut});
	endtask : acc

	task automatic frame();
		logic [11:0] w;
		frameStrobe = 1'b1;
		@(negedge mclk);
		frameStrobe = 1'b0;
		@(negedge mclk);
		for (int ch = 0; ch < 2; ch++) begin
			w = expWord(ch);
			chk("active", {31'h0, ~regsQ[0][PDA_POS-ch]}, {31'h0, lanes[ch].active});
			if (!regsQ[0][PDA_POS-ch]) begin
				chk("overrange", {31'h0, overrangeIn[ch]}, {31'h0, lanes[ch].overrange});
				if (regsQ[0][LANE_POS]) begin
					chk("upper", {20'h0, w}, {20'h0, lanes[ch].upper});
					chk("lowerEn", 32'h0, {31'h0, lanes[ch].lowerEn});
				end else begin
					chk("dual upper", {26'h0, regsQ[0][ALIGN_POS] ? prevHi[ch] : w[11:6]},
						{26'h0, lanes[ch].upper[5:0]});
					chk("dual lower", {26'h0, w[5:0]}, {26'h0, lanes[ch].lower});
					chk("lowerEn", 32'h1, {31'h0, lanes[ch].lowerEn});
				end
				prevHi[ch] = w[11:6];
			end
		end
		overrangeIn = ~overrangeIn;
		// New samples each frame so a delayed upper lane is visible
		samples = {samples[0], samples[1]};
	endtask : frame

	// -------------------------------
	// Main sequence
	// -------------------------------
	initial begin
		logic [7:0] cfg [0:3];
		cfg = '{8'h28, 8'h00, 8'h12, 8'h21};
		nrst = 1'b0;
		frameStrobe = 1'b0;
		samples = {12'h3c5, 12'h81a};
		overrangeIn = 2'b10;
		fails = 0;
		nTests = 0;
		regsQ[0] = DEV_CTRL_RESET;
		regsQ[1] = PAT_HI_RESET;
		regsQ[2] = PAT_LO_RESET;
		ptrQ = PTR_RESET;
		prevHi[0] = 6'h00;
		prevHi[1] = 6'h00;
		repeat (12) @(negedge mclk);
		nrst = 1'b1;
		repeat (2) @(negedge mclk);
		acc(1'b1, ADDR_DEV_CTRL, 8'h00, 16);
		$display("test reset_readback done");
		acc(1'b0, ADDR_PAT_HI, 8'hff, 16);
		acc(1'b0, ADDR_PAT_LO, 8'h5a, 16);
		acc(1'b1, 4'h3, 8'h00, 16);
		acc(1'b0, 4'hf, 8'h77, 16);
		acc(1'b1, ADDR_PAT_HI, 8'haa, 16);
		acc(1'b1, ADDR_PAT_LO, 8'h00, 16);
		$display("test register_access done");
		acc(1'b0, ADDR_DEV_CTRL, 8'hc3, 1);
		acc(1'b0, ADDR_DEV_CTRL, 8'hc3, 15);
		acc(1'b1, ADDR_DEV_CTRL, 8'h00, 16);
		$display("test short_access done");
		for (int m = 0; m < 4; m++) begin
			acc(1'b0, ADDR_DEV_CTRL, {m[1:0], 6'h20}, 16);
			frame();
		end
		$display("test pattern_modes done");
		for (int k = 0; k < 4; k++) begin
			acc(1'b0, ADDR_DEV_CTRL, cfg[k], 16);
			frame();
		end
		acc(1'b0, ADDR_DEV_CTRL, 8'h04, 16);
		frame();
		frame();
		$display("test lane_config done");
		giveVerdict();
	end

	initial begin
		#400000;
		fails++;
		$display("[FAIL] watchdog expected finish seen hang");
		giveVerdict();
	end
endmodule : testbench
